// File: uef_pkg.sv
// endpoint fifo-reset / interrupt register bank: shared constants and types
// assumes an 8-bit special function register port in the core clock domain
package uef_pkg;
   localparam int          EP_COUNT       = 3;
   localparam int          SRC_COUNT      = 5;
   localparam logic [7:0]  ADDR_IRQ_EN    = 8'hC2;
   localparam logic [7:0]  ADDR_FIFO_RST  = 8'hD5;
   localparam logic [7:0]  ADDR_IRQ_FLAGS = 8'hF8;
   localparam logic [7:0]  RESET_IRQ_EN   = 8'h00;
   localparam logic [7:0]  RESET_FIFO_RST = 8'h00;
   localparam int          SRC_IN_SENT    = 0;
   localparam int          SRC_OUT_BANK0  = 1;
   localparam int          SRC_SETUP      = 2;
   localparam int          SRC_STALL_CRC  = 3;
   localparam int          SRC_OUT_BANK1  = 4;

   // one endpoint's interrupt sources
   typedef struct packed {
      logic out_bank1_full_flag;
      logic stall_sent_or_crc_flag;
      logic setup_received_flag;
      logic out_bank0_full_flag;
      logic in_sent_flag;
   } uef_src_t;

   // special function register access
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } uef_sfr_t;
endpackage

// File: uef_regs.sv
// endpoint fifo reset, interrupt enable and interrupt flag registers
// with the per-endpoint clear pulses and the gated usb interrupt request
// assumes sources and sfr strobes come from logic on clk, no synchronisers
// assumes each fifo empties itself on one clear pulse and stays empty while held
`timescale 1ns/100ps

// Functional notes
// - each endpoint bit 0..2 set then cleared resets that endpoint fifo
// - bits 7..3 of all three registers always read zero
// - fifo reset register resets to all zero
// - enable bit one allows that endpoint's interrupts, zero blocks them
// - flag register is read-only; writes have no effect
// - flag sets on any source and clears when all sources clear
// - flag raises usb interrupt only when its enable bit is set
// - five sources: in sent, out bank0, out bank1, setup, stall or crc
module uef_regs
(
   input  wire logic                              clk,
   input  wire logic                              rstn,
   input  wire uef_pkg::uef_sfr_t                 sfr,
   input  wire uef_pkg::uef_src_t [uef_pkg::EP_COUNT-1:0] ep_src,
   output logic [7:0]                             sfr_rdata,
   output logic [uef_pkg::EP_COUNT-1:0]           fifo_clear,
   output logic [uef_pkg::EP_COUNT-1:0]           fifo_held,
   output logic                                   usb_irq
);
   localparam int N = uef_pkg::EP_COUNT;

   logic [N-1:0] rst_q;
   logic [N-1:0] ien_q;
   logic [N-1:0] flag_q;
   logic [N-1:0] flag_d;
   logic [N-1:0] clear_q;
   logic [7:0]   rdata_q;
   logic         irq_q;

   // reduce one endpoint's sources to a pending level
   function automatic logic any_src(input uef_pkg::uef_src_t s);
      any_src = |s;
   endfunction

   // one write-strobe decode shared by every register and its checks
   function automatic logic wr_hit(input uef_pkg::uef_sfr_t s, input logic [7:0] a);
      wr_hit = s.wr && (s.addr == a);
   endfunction

   // fifo reset register; only low bits kept so upper bits read zero
   // a stray one in bits 7..3 is a firmware fault and is simply dropped
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rst_q <= uef_pkg::RESET_FIFO_RST[N-1:0];
      else if (wr_hit(sfr, uef_pkg::ADDR_FIFO_RST))
         rst_q <= sfr.wdata[N-1:0];
   end

   // interrupt enable register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         ien_q <= uef_pkg::RESET_IRQ_EN[N-1:0];
      else if (wr_hit(sfr, uef_pkg::ADDR_IRQ_EN))
         ien_q <= sfr.wdata[N-1:0];
   end

   // flags follow the sources; no write path reaches them
   generate
      for (genvar e = 0; e < N; e++)
      begin : g_flag
         assign flag_d[e] = any_src(ep_src[e]);
      end
   endgenerate

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         flag_q <= '0;
      else
         flag_q <= flag_d;
   end

   // fifo clear pulse on the falling edge of the reset bit, one cycle wide;
   // the fifo is also held empty while the bit stays set
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         clear_q <= '0;
      else if (wr_hit(sfr, uef_pkg::ADDR_FIFO_RST))
         clear_q <= rst_q & ~sfr.wdata[N-1:0];
      else
         clear_q <= '0;
   end

   assign fifo_clear = clear_q;
   assign fifo_held  = rst_q;

   // registered interrupt request gated by enables
   // one flop of lag keeps usb_irq free of glitches while sources settle
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         irq_q <= 1'b0;
      else
         irq_q <= |(flag_d & ien_q);
   end

   assign usb_irq = irq_q;

   // read data; unmapped addresses read zero
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rdata_q <= 8'h00;
      else if (sfr.rd)
      begin
         case (sfr.addr)
            uef_pkg::ADDR_FIFO_RST:  rdata_q <= {{(8-N){1'b0}}, rst_q};
            uef_pkg::ADDR_IRQ_EN:    rdata_q <= {{(8-N){1'b0}}, ien_q};
            uef_pkg::ADDR_IRQ_FLAGS: rdata_q <= {{(8-N){1'b0}}, flag_q};
            default:                 rdata_q <= 8'h00;
         endcase
      end
   end

   assign sfr_rdata = rdata_q;

   // flag and interrupt checks; one cycle of lag behind the sources is the contract
   a_flag_follows: assert property (@(posedge clk) disable iff (!rstn)
      flag_q == $past(flag_d))
      else $error("flag not following sources");

   a_irq_gated: assert property (@(posedge clk) disable iff (!rstn)
      usb_irq |-> |($past(flag_d) & $past(ien_q)))
      else $error("irq while masked");

   a_irq_raised: assert property (@(posedge clk) disable iff (!rstn)
      (|(flag_d & ien_q)) |=> usb_irq)
      else $error("enabled flag gave no irq");

   a_irq_quiet: assert property (@(posedge clk) disable iff (!rstn)
      !(|(flag_d & ien_q)) |=> !usb_irq)
      else $error("irq without enabled flag");

   a_flags_ro: assert property (@(posedge clk) disable iff (!rstn)
      wr_hit(sfr, uef_pkg::ADDR_IRQ_FLAGS) |=> flag_q == $past(flag_d))
      else $error("flag write took effect");

   // endpoint 0 clear pulse; the loop below repeats the cause check, not the one-cycle width check, for every endpoint
   a_clear_pulse: assert property (@(posedge clk) disable iff (!rstn)
      fifo_clear[0] |=> !fifo_clear[0])
      else $error("clear pulse too long");

   a_clear_cause: assert property (@(posedge clk) disable iff (!rstn)
      fifo_clear[0] |-> $past(rst_q[0]) && !rst_q[0])
      else $error("clear without falling bit");

   // register contents move only on their own write strobe
   a_en_write: assert property (@(posedge clk) disable iff (!rstn)
      wr_hit(sfr, uef_pkg::ADDR_IRQ_EN) |=> ien_q == $past(sfr.wdata[N-1:0]))
      else $error("enable write lost");

   a_en_kept: assert property (@(posedge clk) disable iff (!rstn)
      !wr_hit(sfr, uef_pkg::ADDR_IRQ_EN) |=> $stable(ien_q))
      else $error("enable bits changed");

   a_held_reg: assert property (@(posedge clk) disable iff (!rstn)
      !wr_hit(sfr, uef_pkg::ADDR_FIFO_RST) |=> $stable(rst_q))
      else $error("fifo reset bits changed");

   a_held_write: assert property (@(posedge clk) disable iff (!rstn)
      wr_hit(sfr, uef_pkg::ADDR_FIFO_RST) |=> fifo_held == $past(sfr.wdata[N-1:0]))
      else $error("fifo reset write lost");

   // read path: data stands from the cycle after the strobe until the next read
   a_upper_zero: assert property (@(posedge clk) disable iff (!rstn)
      sfr_rdata[7:3] == 5'h00)
      else $error("upper bits not zero");

   a_rd_fifo: assert property (@(posedge clk) disable iff (!rstn)
      (sfr.rd && sfr.addr == uef_pkg::ADDR_FIFO_RST)
      |=> sfr_rdata == {{(8-N){1'b0}}, $past(rst_q)})
      else $error("fifo reset read wrong");

   a_rd_en: assert property (@(posedge clk) disable iff (!rstn)
      (sfr.rd && sfr.addr == uef_pkg::ADDR_IRQ_EN)
      |=> sfr_rdata == {{(8-N){1'b0}}, $past(ien_q)})
      else $error("enable read wrong");

   a_rd_flags: assert property (@(posedge clk) disable iff (!rstn)
      (sfr.rd && sfr.addr == uef_pkg::ADDR_IRQ_FLAGS)
      |=> sfr_rdata == {{(8-N){1'b0}}, $past(flag_q)})
      else $error("flag read wrong");

   a_rd_unmapped: assert property (@(posedge clk) disable iff (!rstn)
      (sfr.rd && sfr.addr != uef_pkg::ADDR_FIFO_RST && sfr.addr != uef_pkg::ADDR_IRQ_EN
         && sfr.addr != uef_pkg::ADDR_IRQ_FLAGS) |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");

   a_rd_stands: assert property (@(posedge clk) disable iff (!rstn)
      !sfr.rd |=> $stable(sfr_rdata))
      else $error("read data moved without strobe");

   // per endpoint: a stuck or swapped index would slip past the endpoint 0 checks
   generate
      for (genvar e = 0; e < N; e++)
      begin : g_ep_chk
         a_ep_clear_fire: assert property (@(posedge clk) disable iff (!rstn)
            (wr_hit(sfr, uef_pkg::ADDR_FIFO_RST) && rst_q[e] && !sfr.wdata[e])
            |=> fifo_clear[e])
            else $error("endpoint clear pulse missing");

         a_ep_clear_why: assert property (@(posedge clk) disable iff (!rstn)
            fifo_clear[e] |-> $past(fifo_held[e]) && !fifo_held[e])
            else $error("endpoint clear without falling bit");

         a_ep_flag_set: assert property (@(posedge clk) disable iff (!rstn)
            (|ep_src[e]) |=> flag_q[e])
            else $error("endpoint flag not set by source");

         a_ep_flag_drop: assert property (@(posedge clk) disable iff (!rstn)
            !(|ep_src[e]) |=> !flag_q[e])
            else $error("endpoint flag kept without source");
      end
   endgenerate
endmodule

// File: uef_tb.sv
// bench for the endpoint fifo reset and interrupt register bank
// assumes uef_regs as declared; strobes are one cycle, driven on falling edges
`timescale 1ns/100ps
module testbench;
   logic                    clk;
   logic                    rstn;
   logic                    rd_seen;
   uef_pkg::uef_sfr_t       sfr;
   uef_pkg::uef_src_t [2:0] src;
   logic [7:0]              rdata;
   logic [2:0]              clr;
   logic [2:0]              held;
   logic                    irq;
   logic [2:0]              en;
   logic [2:0]              f;
   logic [7:0]              exp_q[$];
   logic [31:0]             seed = 32'h49C62DCF;
   int                      failures = 0;
   int                      total_checks = 0;

   uef_regs dut_u (.clk(clk), .rstn(rstn), .sfr(sfr), .ep_src(src), .sfr_rdata(rdata),
      .fifo_clear(clr), .fifo_held(held), .usb_irq(irq));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(logic [7:0] seen, logic [7:0] want);
      total_checks++;
      if (seen !== want)
      begin
         failures++;
         $display("MISMATCH %0t saw %h want %h", $time, seen, want);
      end
   endtask

   // one strobe cycle, released on the next falling edge
   task automatic bus(logic w, logic r, logic [7:0] a, logic [7:0] d);
      @(negedge clk);
      sfr = '{w, r, a, d};
      @(negedge clk);
      sfr = '0;
   endtask

   task automatic rd(logic [7:0] a, logic [7:0] want);
      exp_q.push_back(want);
      bus(1'b0, 1'b1, a, 8'h00);
   endtask

   task automatic complete_run();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // read data lands one cycle after the strobe; oldest note is compared
   always @(posedge clk) rd_seen <= sfr.rd;
   always @(negedge clk)
      if (rd_seen === 1'b1)
         chk(rdata, exp_q.size() ? exp_q.pop_front() : 8'hEE);

   initial
   begin
      rstn = 1'b0;
      sfr = '0;
      src = '0;
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      rd(uef_pkg::ADDR_IRQ_EN, 8'h00);
      rd(uef_pkg::ADDR_FIFO_RST, 8'h00);
      rd(8'h00, 8'h00);
      $display("reset values done");
      for (int i = 0; i < 3; i++)
      begin
         bus(1'b1, 1'b0, uef_pkg::ADDR_FIFO_RST, 8'(1 << i));
         chk(8'(held), 8'(1 << i));
         rd(uef_pkg::ADDR_FIFO_RST, 8'(1 << i));
         bus(1'b1, 1'b0, uef_pkg::ADDR_FIFO_RST, 8'h00);
         chk(8'(clr), 8'(1 << i));
         @(negedge clk);
         chk(8'(clr), 8'h00);
      end
      $display("fifo clear done");
      for (int k = 0; k < 8; k++)
      begin
         en = 3'(rnd());
         src = 15'(rnd());
         bus(1'b1, 1'b0, uef_pkg::ADDR_IRQ_EN, {5'h00, en});
         bus(1'b1, 1'b0, uef_pkg::ADDR_IRQ_FLAGS, {5'h00, 3'(rnd())});
         for (int i = 0; i < 3; i++) f[i] = |src[i];
         chk(8'(irq), 8'(|(f & en)));
         rd(uef_pkg::ADDR_IRQ_FLAGS, {5'h00, f});
         rd(uef_pkg::ADDR_IRQ_EN, {5'h00, en});
      end
      $display("interrupt flags done");
      src = 15'h0020;
      bus(1'b1, 1'b0, uef_pkg::ADDR_IRQ_EN, 8'h07);
      @(negedge clk);
      chk(8'(irq), 8'h01);
      rd(uef_pkg::ADDR_IRQ_FLAGS, 8'h02);
      src = '0;
      repeat (2) @(negedge clk);
      chk(8'(irq), 8'h00);
      rd(uef_pkg::ADDR_IRQ_FLAGS, 8'h00);
      $display("sources drop done");
      repeat (2) @(negedge clk);
      chk(8'(exp_q.size()), 8'h00);
      complete_run();
   end
endmodule
